// file: logic/rtc_subsecond_shift_timestamp.sv
/*
  Sub-second counter, fine time shift and time-stamp capture of a real-time
  clock. Assumes the rest of the clock supplies a prescaler tick, the
  calendar time and date, and the stamp trigger; bkp_reset_i is the backup
  domain reset, reset_i the system reset. Both are synchronous, active high.
*/
`timescale 1ns/1ns
`include "rtc_ss_defines.svh"
module rtc_subsecond_shift_timestamp
  import rtc_ss_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic bkp_reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic prescale_tick_i,
  input wire logic [15:0] sync_prescale_factor_i,
  input wire logic shadow_bypass_i,
  input wire logic stamp_event_i,
  input wire logic stamp_clear_i,
  input wire cal_time_t cal_time_i,
  input wire cal_date_t cal_date_i,
  input wire logic sync_done_i,
  output logic second_tick_o,
  output logic add_second_o,
  output logic shift_pending_flag_o,
  output logic register_synced_flag_o,
  output logic stamp_flag_o,
  output logic [15:0] subsecond_value_o
);

  // ========================================================================
  // State
  logic [15:0] count_q;
  shift_req_t shift_q;
  shift_state_t state_q;
  logic synced_q;
  logic stamp_q;
  cal_time_t st_time_q;
  cal_date_t st_date_q;
  logic [15:0] st_sub_q;
  logic second_q;
  logic add_sec_q;

  logic shift_wr;
  logic apply;
  logic [15:0] shifted;

  assign shift_wr = wr_i && (addr_i == `OFS_TIME_SHIFT);
  assign apply = (state_q == SH_APPLY);
  // A count above the factor only lengthens the current second. The sum
  // wraps at 16 bits; software keeps the factor plus the fraction in range.
  assign shifted = count_q + {1'b0, shift_q.subtract_fraction};

  // ========================================================================
  // Synchronous prescaler down counter
  always_ff @(posedge sys_clk_i) begin
    if (bkp_reset_i) begin
      count_q <= `RST_SUBSEC;
    end else if (reset_i && !shadow_bypass_i) begin
      count_q <= `RST_SUBSEC;
    end else if (apply) begin
      // A tick that meets the apply cycle is dropped; that one-tick window
      // is the price of landing the whole shift in a single cycle.
      count_q <= shifted;
    end else if (prescale_tick_i) begin
      if (count_q == 16'h0000) begin
        count_q <= sync_prescale_factor_i;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || bkp_reset_i) begin
      second_q <= 1'b0;
    end else begin
      second_q <= prescale_tick_i && !apply && (count_q == 16'h0000);
    end
  end

  // ========================================================================
  // Shift request register and its sequence
  always_ff @(posedge sys_clk_i) begin
    if (bkp_reset_i) begin
      shift_q <= '0;
    end else if (shift_wr && state_q == SH_IDLE) begin
      shift_q.add_one_second <= wdata_i[`BIT_ADD_ONE_SECOND];
      shift_q.subtract_fraction <= wdata_i[`SFS_MSB:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (bkp_reset_i || reset_i) begin
      state_q <= SH_IDLE;
    end else begin
      case (state_q)
        SH_IDLE: begin
          if (shift_wr) begin
            state_q <= SH_APPLY;
          end
        end
        SH_APPLY: state_q <= SH_DONE;
        SH_DONE: state_q <= SH_IDLE;
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || bkp_reset_i) begin
      add_sec_q <= 1'b0;
    end else begin
      add_sec_q <= apply && shift_q.add_one_second;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || bkp_reset_i) begin
      synced_q <= 1'b0;
    end else if (sync_done_i) begin
      // A sync that meets a write wins, so a finished resync is never lost.
      synced_q <= 1'b1;
    end else if (shift_wr) begin
      synced_q <= 1'b0;
    end
  end

  // ========================================================================
  // Time stamp
  always_ff @(posedge sys_clk_i) begin
    if (bkp_reset_i) begin
      stamp_q <= 1'b0;
    end else if (stamp_event_i) begin
      stamp_q <= 1'b1;
    end else if (stamp_clear_i) begin
      stamp_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (bkp_reset_i) begin
      st_time_q <= '0;
      st_date_q <= '0;
      st_sub_q <= `RST_SUBSEC;
    end else if (stamp_event_i && !stamp_q) begin
      st_time_q <= cal_time_i;
      st_date_q <= cal_date_i;
      st_sub_q <= count_q;
    end else if (stamp_clear_i && !stamp_event_i) begin
      st_time_q <= '0;
      st_date_q <= '0;
      st_sub_q <= `RST_SUBSEC;
    end
  end

  // ========================================================================
  // Register read port
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o <= `RST_WORD;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_SUBSECOND_COUNT: rdata_o <= {16'h0000, count_q};
        `OFS_STAMP_TIME: rdata_o <= {9'h000, st_time_q[20:14], 1'b0,
                                     st_time_q[13:7], 1'b0,
                                     st_time_q[6:0]};
        `OFS_STAMP_DATE: rdata_o <= {16'h0000, st_date_q[13:6], 2'b00,
                                     st_date_q[5:0]};
        `OFS_STAMP_SUBSECOND: rdata_o <= {16'h0000, st_sub_q};
        `OFS_SHIFT_STATUS: rdata_o <= {29'h0000_0000, stamp_q, synced_q,
                                       state_q != SH_IDLE};
        default: rdata_o <= `RST_WORD;
      endcase
    end else begin
      rdata_o <= `RST_WORD;
    end
  end

  assign second_tick_o = second_q;
  assign add_second_o = add_sec_q;
  assign shift_pending_flag_o = (state_q != SH_IDLE);
  assign register_synced_flag_o = synced_q;
  assign stamp_flag_o = stamp_q;
  assign subsecond_value_o = count_q;

endmodule

// file: include/rtc_ss_defines.svh
/*
  Register offsets, field positions and reset values for the sub-second,
  time-shift and time-stamp block. Assumes byte-addressed 32-bit registers.
*/
`ifndef RTC_SS_DEFINES_SVH
`define RTC_SS_DEFINES_SVH

// ==========================================================================
// Register offsets
`define OFS_SUBSECOND_COUNT 8'h28
`define OFS_TIME_SHIFT 8'h2C
`define OFS_STAMP_TIME 8'h30
`define OFS_STAMP_DATE 8'h34
`define OFS_STAMP_SUBSECOND 8'h38
`define OFS_SHIFT_STATUS 8'h50
`define OFS_SHIFT_APPLY_CTRL 8'h54

// ==========================================================================
// Field positions
`define BIT_ADD_ONE_SECOND 31
`define SFS_MSB 14
`define BIT_PENDING 0
`define BIT_SYNCED 1
`define BIT_STAMP 2

// ==========================================================================
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_SUBSEC 16'h0000
`define RST_FACTOR 16'h00FF

`endif

// file: include/rtc_ss_pkg.sv
/*
  Types shared by the sub-second block. Assumes nothing else.
*/
package rtc_ss_pkg;
  typedef struct packed {
    logic afternoon_mark;
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
    logic [2:0] minute_tens;
    logic [3:0] minute_units;
    logic [2:0] second_tens;
    logic [3:0] second_units;
  } cal_time_t;

  typedef struct packed {
    logic [2:0] weekday;
    logic mth_tens;
    logic [3:0] mth_units;
    logic [1:0] day_tens_digit;
    logic [3:0] day_units_digit;
  } cal_date_t;

  typedef struct packed {
    logic add_one_second;
    logic [14:0] subtract_fraction;
  } shift_req_t;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_APPLY,
    SH_DONE
  } shift_state_t;
endpackage

// file: bench/rtc_ss_asserts.sv
/* Checker for the sub-second, shift and stamp block.
   Assumes it is bound to the block and sees its ports by name. */
`timescale 1ns/1ns
// ===================================================
// Port timing checks
module rtc_ss_asserts (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic bkp_reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic prescale_tick_i,
  input wire logic stamp_event_i,
  input wire logic stamp_clear_i,
  input wire logic sync_done_i,
  input wire logic second_tick_o,
  input wire logic add_second_o,
  input wire logic shift_pending_flag_o,
  input wire logic register_synced_flag_o,
  input wire logic stamp_flag_o,
  input wire logic [15:0] subsecond_value_o
);
  logic [15:0] frac_w;
  assign frac_w = {1'b0, wdata_i[14:0]};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i || bkp_reset_i);
  sequence s_shw;
    wr_i && addr_i == 8'h2C && !shift_pending_flag_o;
  endsequence
  // Ticks are excluded so the sum is the shift alone.
  sequence s_quiet;
    s_shw ##0 !prescale_tick_i ##1 !prescale_tick_i;
  endsequence
  property p_rdi; !rd_i |=> rdata_o == 32'h0; endproperty
  property p_rss;
    rd_i && addr_i == 8'h28 |=> rdata_o == {16'h0, $past(subsecond_value_o)};
  endproperty
  property p_syn;
    wr_i && addr_i == 8'h2C && !sync_done_i |=> !register_synced_flag_o;
  endproperty
  property p_pnd;
    s_shw |=> shift_pending_flag_o [*2] ##1 !shift_pending_flag_o;
  endproperty
  property p_add; s_shw ##0 wdata_i[31] |-> ##2 add_second_o; endproperty
  property p_nad; s_shw ##0 !wdata_i[31] |-> ##2 !add_second_o; endproperty
  property p_sec;
    prescale_tick_i && subsecond_value_o == 16'h0000 && !shift_pending_flag_o
      |=> second_tick_o;
  endproperty
  property p_frc;
    s_quiet |=> subsecond_value_o ==
      $past(subsecond_value_o, 2) + $past(frac_w, 2);
  endproperty
  property p_tss; stamp_event_i && !stamp_flag_o |=> stamp_flag_o;
  endproperty
  property p_tsc; stamp_clear_i && !stamp_event_i |=> !stamp_flag_o;
  endproperty
  a_rdi: assert property (p_rdi) else $error("rdata idle");
  a_rss: assert property (p_rss) else $error("subsec read");
  a_syn: assert property (p_syn) else $error("synced kept");
  a_pnd: assert property (p_pnd) else $error("pending");
  a_add: assert property (p_add) else $error("add second");
  a_nad: assert property (p_nad) else $error("second added");
  a_sec: assert property (p_sec) else $error("second tick");
  a_frc: assert property (p_frc) else $error("fraction");
  a_tss: assert property (p_tss) else $error("stamp set");
  a_tsc: assert property (p_tsc) else $error("stamp clear");
endmodule
bind rtc_subsecond_shift_timestamp rtc_ss_asserts i_rtc_ss_asserts (.*);

// file: bench/rtc_subsecond_shift_timestamp_bench.sv
/* Self-checking bench for the sub-second, shift and stamp block.
   Assumes one 250 MHz clock and the checker bound on its own. */
`timescale 1ns/1ns
module rtc_subsecond_shift_timestamp_bench;
  import rtc_ss_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, bkp_reset_i = 1'b1;
  logic wr_i = 1'b0, rd_i = 1'b0, prescale_tick_i = 1'b0;
  logic shadow_bypass_i = 1'b0, stamp_event_i = 1'b0;
  logic stamp_clear_i = 1'b0, sync_done_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [15:0] sync_prescale_factor_i = 16'h00FF, subsecond_value_o;
  logic second_tick_o, add_second_o, shift_pending_flag_o;
  logic register_synced_flag_o, stamp_flag_o;
  cal_time_t cal_time_i = '{1'b1, 2'h1, 4'h2, 3'h3, 4'h4, 3'h5, 4'h6};
  cal_date_t cal_date_i = '{3'h5, 1'b1, 4'h2, 2'h2, 4'h8};
  int errors = 0, num_checks = 0;
  rtc_subsecond_shift_timestamp i_rtc_subsecond_shift_timestamp (.*);
  always #2 sys_clk_i = ~sys_clk_i;
  // ===================================================
  // Check, bus, tick, reset and finish tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand one cycle only, so they are taken mid-cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata_o, e);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      prescale_tick_i <= 1'b1;
      @(posedge sys_clk_i);
      prescale_tick_i <= 1'b0;
    end
  endtask
  task automatic rst(input logic byp);
    @(posedge sys_clk_i);
    shadow_bypass_i <= byp;
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ===================================================
  // Stimulus
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    bkp_reset_i <= 1'b0;
    rd(8'h2C, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h3C, 32'h0);
    tick(4);
    rd(8'h28, 32'h0000_00FC);
    wr(8'h2C, 32'h8000_0010);
    wr(8'h2C, 32'h0000_0005);
    repeat (3) @(posedge sys_clk_i);
    rd(8'h28, 32'h0000_010C);
    wr(8'h2C, 32'h0000_0005);
    repeat (3) @(posedge sys_clk_i);
    rd(8'h28, 32'h0000_0111);
    @(posedge sys_clk_i);
    sync_done_i <= 1'b1;
    @(posedge sys_clk_i);
    sync_done_i <= 1'b0;
    rd(8'h50, 32'h0000_0002);
    wr(8'h2C, 32'h0000_0000);
    rd(8'h50, 32'h0000_0001);
    @(posedge sys_clk_i);
    stamp_event_i <= 1'b1;
    @(posedge sys_clk_i);
    stamp_event_i <= 1'b0;
    rd(8'h30, 32'h0052_3456);
    rd(8'h34, 32'h0000_B228);
    rd(8'h38, 32'h0000_0111);
    rd(8'h50, 32'h0000_0004);
    rst(1'b1);
    rd(8'h28, 32'h0000_0111);
    rst(1'b0);
    rd(8'h28, 32'h0);
    rd(8'h30, 32'h0052_3456);
    @(posedge sys_clk_i);
    stamp_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    stamp_clear_i <= 1'b0;
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h38, 32'h0);
    end_sim;
  end
  initial begin
    #10000;
    errors++;
    end_sim;
  end
endmodule
